// ### common/pmev_pkg.sv
package pmev_pkg;

  // Register byte addresses on the APB.
  localparam logic [31:0] RANGE_BASE_OFS = 32'hffffff6c;
  localparam logic [31:0] RANGE_MASK_OFS = 32'hffffff7c;
  localparam logic [31:0] CTRL_OFS = 32'hffffff00;
  localparam logic [31:0] PKT_OFS = 32'hffffff04;
  localparam logic [31:0] IRQ_STAT_OFS = 32'hffffff08;
  localparam logic [31:0] IRQ_CLR_OFS = 32'hffffff0c;
  localparam logic [31:0] IRQ_EN_OFS = 32'hffffff10;

  // Field positions.
  localparam int unsigned ADDR_LO = 2;
  localparam int unsigned ADDR_HI = 27;
  localparam int unsigned ADDR_W = ADDR_HI - ADDR_LO + 1;
  localparam int unsigned MASK_RD_EN_BIT = 0;
  localparam int unsigned MASK_WE_BIT = 1;
  localparam int unsigned CTRL_VID_EN_BIT = 0;
  localparam int unsigned CTRL_INTV_LO = 3;
  localparam int unsigned CTRL_INTV_HI = 4;
  localparam int unsigned PKT_VID_BIT = 0;
  localparam int unsigned PKT_RANGE_BIT = 1;
  localparam int unsigned PKT_LIVE_W = 2;
  localparam int unsigned PKT_W = 8;
  localparam int unsigned IRQ_VID_BIT = 0;
  localparam int unsigned IRQ_RANGE_BIT = 1;
  localparam int unsigned IRQ_SENT_BIT = 2;
  localparam int unsigned IRQ_W = 3;

  // Values after reset.
  localparam logic [ADDR_W-1:0] RANGE_FIELD_RST = 26'h0000000;
  localparam logic [1:0] CYC_SEL_RST = 2'h0;
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;

  // Send intervals in milliseconds and their cycle counts at 125 MHz.
  localparam int unsigned CLK_KHZ = 125000;
  localparam int unsigned INTV_A_MS = 1;
  localparam int unsigned INTV_B_MS = 5;
  localparam int unsigned INTV_C_MS = 10;
  localparam int unsigned INTV_A_CYC = INTV_A_MS * CLK_KHZ;
  localparam int unsigned INTV_B_CYC = INTV_B_MS * CLK_KHZ;
  localparam int unsigned INTV_C_CYC = INTV_C_MS * CLK_KHZ;

  typedef enum logic [1:0] {
    INTV_OFF = 2'b00,
    INTV_A = 2'b01,
    INTV_B = 2'b10,
    INTV_C = 2'b11
  } pmev_intv_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic video;
    logic [31:0] addr;
  } pmev_cyc_t;

  typedef struct packed {
    logic strobe;
    logic [PKT_W-1:0] data;
  } pmev_pkt_t;

endpackage : pmev_pkg

// ### logic/pmev_range_cmp.sv
`timescale 1ns/1ps
module pmev_range_cmp #(
  parameter int unsigned AW = pmev_pkg::ADDR_W
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire pmev_pkg::pmev_cyc_t cyc,
  input wire logic [AW-1:0] base,
  input wire logic [AW-1:0] mask,
  input wire logic rd_en,
  input wire logic wr_en,
  output logic hit
);
  logic [AW-1:0] bit_ok;
  logic type_ok;
  logic hit_ff;

  genvar gi;
  generate
    for (gi = 0; gi < AW; gi++) begin : g_bit
      // A set mask bit always matches; a clear one needs equality.
      assign bit_ok[gi] = mask[gi] | (cyc.addr[pmev_pkg::ADDR_LO + gi] == base[gi]);
    end
  endgenerate

  assign type_ok = cyc.write ? wr_en : rd_en;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hit_ff <= 1'b0;
    end else begin
      hit_ff <= cyc.valid & type_ok & (&bit_ok);
    end
  end

  assign hit = hit_ff;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  property p_mismatch_no_hit;
    cyc.valid && (((cyc.addr[27:2] ^ base) & ~mask) != '0) |=> !hit_ff;
  endproperty
  a_mismatch_no_hit: assert property (p_mismatch_no_hit) else $error("unmasked mismatch hit");

  property p_masked_hit;
    cyc.valid && !cyc.write && rd_en && (((cyc.addr[27:2] ^ base) & ~mask) == '0) |=> hit_ff;
  endproperty
  a_masked_hit: assert property (p_masked_hit) else $error("masked read missed");

  property p_wr_off;
    cyc.valid && cyc.write && !wr_en |=> !hit_ff;
  endproperty
  a_wr_off: assert property (p_wr_off) else $error("write hit while off");

  property p_rd_off;
    cyc.valid && !cyc.write && !rd_en |=> !hit_ff;
  endproperty
  a_rd_off: assert property (p_rd_off) else $error("read hit while off");

endmodule : pmev_range_cmp

// ### logic/pmev_intv_timer.sv
`timescale 1ns/1ps
module pmev_intv_timer #(
  parameter int unsigned CYC_A = pmev_pkg::INTV_A_CYC,
  parameter int unsigned CYC_B = pmev_pkg::INTV_B_CYC,
  parameter int unsigned CYC_C = pmev_pkg::INTV_C_CYC,
  parameter int unsigned CW = 24
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [1:0] sel,
  input wire logic restart,
  output logic expired
);
  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] limit;
  logic exp_ff;
  logic off;

  // Limits sit two cycles short because the registered expiry and the restarting send each cost a cycle.
  always_comb begin
    unique case (pmev_pkg::pmev_intv_t'(sel))
      pmev_pkg::INTV_OFF: limit = '0;
      pmev_pkg::INTV_A: limit = CW'(CYC_A - 2);
      pmev_pkg::INTV_B: limit = CW'(CYC_B - 2);
      pmev_pkg::INTV_C: limit = CW'(CYC_C - 2);
    endcase
  end

  assign off = (sel == pmev_pkg::INTV_OFF);

  // A shortened interval taking effect mid-count expires at once if the count has already reached the new limit.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= '0;
    end else if (restart || off) begin
      cnt_ff <= '0;
    end else if (!exp_ff && cnt_ff < limit) begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      exp_ff <= 1'b0;
    end else if (restart || off) begin
      exp_ff <= 1'b0;
    end else if (cnt_ff >= limit) begin
      exp_ff <= 1'b1;
    end
  end

  assign expired = exp_ff;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  property p_exp_cause;
    $rose(exp_ff) |-> $past(cnt_ff >= limit) && $past(!off) && $past(!restart);
  endproperty
  a_exp_cause: assert property (p_exp_cause) else $error("early expiry");

endmodule : pmev_intv_timer

// ### logic/pmev_top.sv
`timescale 1ns/1ps
module pmev_top #(
  parameter int unsigned CYC_A = pmev_pkg::INTV_A_CYC,
  parameter int unsigned CYC_B = pmev_pkg::INTV_B_CYC,
  parameter int unsigned CYC_C = pmev_pkg::INTV_C_CYC
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [31:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire pmev_pkg::pmev_cyc_t cpu_cyc,
  output pmev_pkg::pmev_pkt_t ser_pkt,
  output logic irq
);
  localparam int unsigned AW = pmev_pkg::ADDR_W;
  localparam int unsigned LW = pmev_pkg::PKT_LIVE_W;
  localparam int unsigned IW = pmev_pkg::IRQ_W;

  // Register state.
  logic [AW-1:0] base_ff;
  logic [AW-1:0] mask_ff;
  logic [1:0] cyc_sel_ff;
  logic [2:0] ctrl_ff;
  logic [LW-1:0] pkt_ff;
  logic [IW-1:0] stat_ff;
  logic [IW-1:0] en_ff;
  logic irq_ff;

  // Bus answer and packet output state.
  logic pready_ff;
  logic pslverr_ff;
  logic [31:0] prdata_ff;
  pmev_pkg::pmev_pkt_t pkt_out_ff;

  // Working signals.
  logic acc;
  logic wr_fire;
  logic hit_base;
  logic hit_mask;
  logic hit_ctrl;
  logic hit_pkt;
  logic hit_stat;
  logic hit_clr;
  logic hit_en;
  logic mapped;
  logic [31:0] nxt_prdata;
  logic vid_en;
  logic [1:0] intv_sel;
  logic vid_ev;
  logic range_ev;
  logic tmr_exp;
  logic send;
  logic [LW-1:0] ev_set;
  logic [LW-1:0] nxt_pkt;
  logic [IW-1:0] irq_set;
  logic [IW-1:0] irq_clr;
  logic [IW-1:0] nxt_stat;

  // Address decode.
  assign hit_base = (paddr == pmev_pkg::RANGE_BASE_OFS);
  assign hit_mask = (paddr == pmev_pkg::RANGE_MASK_OFS);
  assign hit_ctrl = (paddr == pmev_pkg::CTRL_OFS);
  assign hit_pkt = (paddr == pmev_pkg::PKT_OFS);
  assign hit_stat = (paddr == pmev_pkg::IRQ_STAT_OFS);
  assign hit_clr = (paddr == pmev_pkg::IRQ_CLR_OFS);
  assign hit_en = (paddr == pmev_pkg::IRQ_EN_OFS);
  assign mapped = hit_base | hit_mask | hit_ctrl | hit_pkt | hit_stat | hit_clr | hit_en;

  // The answer is registered, so every access phase lasts two cycles.
  assign acc = psel & penable & ~pready_ff;
  assign wr_fire = psel & penable & pready_ff & pwrite & ~pslverr_ff;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff <= acc;
      pslverr_ff <= acc & ~mapped;
    end
  end

  always_comb begin
    nxt_prdata = 32'h00000000;
    if (hit_base) begin
      nxt_prdata[pmev_pkg::ADDR_HI:pmev_pkg::ADDR_LO] = base_ff;
    end
    if (hit_mask) begin
      nxt_prdata[pmev_pkg::ADDR_HI:pmev_pkg::ADDR_LO] = mask_ff;
      nxt_prdata[1:0] = cyc_sel_ff;
    end
    if (hit_ctrl) begin
      nxt_prdata[pmev_pkg::CTRL_INTV_HI:pmev_pkg::CTRL_INTV_LO] = ctrl_ff[2:1];
      nxt_prdata[pmev_pkg::CTRL_VID_EN_BIT] = ctrl_ff[0];
    end
    if (hit_pkt) begin
      nxt_prdata[LW-1:0] = pkt_ff;
    end
    if (hit_stat) begin
      nxt_prdata[IW-1:0] = stat_ff;
    end
    if (hit_en) begin
      nxt_prdata[IW-1:0] = en_ff;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_ff <= 32'h00000000;
    end else if (acc && !pwrite) begin
      prdata_ff <= nxt_prdata;
    end else if (acc) begin
      prdata_ff <= 32'h00000000;
    end
  end

  // Only the live fields are stored, so reserved bits are dropped on write.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      base_ff <= pmev_pkg::RANGE_FIELD_RST;
    end else if (wr_fire && hit_base) begin
      base_ff <= pwdata[pmev_pkg::ADDR_HI:pmev_pkg::ADDR_LO];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_ff <= pmev_pkg::RANGE_FIELD_RST;
      cyc_sel_ff <= pmev_pkg::CYC_SEL_RST;
    end else if (wr_fire && hit_mask) begin
      mask_ff <= pwdata[pmev_pkg::ADDR_HI:pmev_pkg::ADDR_LO];
      cyc_sel_ff <= pwdata[1:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff <= pmev_pkg::CTRL_RST;
    end else if (wr_fire && hit_ctrl) begin
      ctrl_ff <= {pwdata[pmev_pkg::CTRL_INTV_HI:pmev_pkg::CTRL_INTV_LO],
                  pwdata[pmev_pkg::CTRL_VID_EN_BIT]};
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      en_ff <= pmev_pkg::IRQ_RST;
    end else if (wr_fire && hit_en) begin
      en_ff <= pwdata[IW-1:0];
    end
  end

  assign vid_en = ctrl_ff[0];
  assign intv_sel = ctrl_ff[2:1];

  // The display decode arrives already qualified from the same clock domain.
  assign vid_ev = cpu_cyc.valid & cpu_cyc.video & vid_en;

  pmev_range_cmp #(
    .AW(AW)
  ) u_cmp (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .cyc(cpu_cyc),
    .base(base_ff),
    .mask(mask_ff),
    .rd_en(cyc_sel_ff[pmev_pkg::MASK_RD_EN_BIT]),
    .wr_en(cyc_sel_ff[pmev_pkg::MASK_WE_BIT]),
    .hit(range_ev)
  );

  pmev_intv_timer #(
    .CYC_A(CYC_A),
    .CYC_B(CYC_B),
    .CYC_C(CYC_C)
  ) u_tmr (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .sel(intv_sel),
    .restart(send),
    .expired(tmr_exp)
  );

  // Packet accumulation; a new event in the send cycle survives the clear.
  assign send = tmr_exp & (|pkt_ff);
  assign ev_set[pmev_pkg::PKT_VID_BIT] = vid_ev;
  assign ev_set[pmev_pkg::PKT_RANGE_BIT] = range_ev;
  assign nxt_pkt = (send ? '0 : pkt_ff) | ev_set;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pkt_ff <= '0;
    end else begin
      pkt_ff <= nxt_pkt;
    end
  end

  // The packet leaves as one strobe carrying the whole register image.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pkt_out_ff <= '0;
    end else begin
      pkt_out_ff.strobe <= send;
      pkt_out_ff.data <= send ? {{(pmev_pkg::PKT_W - LW){1'b0}}, pkt_ff} : '0;
    end
  end

  // Interrupt status: set wins over a clear in the same cycle.
  assign irq_set = {send, range_ev, vid_ev};
  assign irq_clr = (wr_fire && hit_clr) ? pwdata[IW-1:0] : '0;
  assign nxt_stat = (stat_ff & ~irq_clr) | irq_set;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      stat_ff <= pmev_pkg::IRQ_RST;
    end else begin
      stat_ff <= nxt_stat;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(nxt_stat & en_ff);
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign ser_pkt = pkt_out_ff;
  assign irq = irq_ff;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_vid_event;
    cpu_cyc.valid && cpu_cyc.video && ctrl_ff[0];
  endsequence

  sequence s_send;
    tmr_exp && (pkt_ff != '0);
  endsequence

  property p_vid_sets;
    s_vid_event |=> pkt_ff[0];
  endproperty
  a_vid_sets: assert property (p_vid_sets) else $error("video event lost");

  property p_vid_gate;
    $rose(pkt_ff[0]) |-> $past(cpu_cyc.valid && cpu_cyc.video && ctrl_ff[0]);
  endproperty
  a_vid_gate: assert property (p_vid_gate) else $error("video bit without enable");

  property p_send_cause;
    pkt_out_ff.strobe |-> $past(tmr_exp) && $past(pkt_ff != '0);
  endproperty
  a_send_cause: assert property (p_send_cause) else $error("packet sent without cause");

  property p_hold;
    (pkt_ff[1] && !send) |=> pkt_ff[1];
  endproperty
  a_hold: assert property (p_hold) else $error("event bit dropped early");

  property p_clear;
    s_send ##0 (ev_set == '0) |=> (pkt_ff == '0) ##0 pkt_out_ff.strobe;
  endproperty
  a_clear: assert property (p_clear) else $error("bits not cleared after send");

  property p_merge;
    pkt_ff[0] && !send && vid_ev |=> pkt_ff[0] && !pkt_out_ff.strobe;
  endproperty
  a_merge: assert property (p_merge) else $error("repeat event misbehaved");

  property p_accum;
    s_send |=> pkt_out_ff.data == {6'h00, $past(pkt_ff)};
  endproperty
  a_accum: assert property (p_accum) else $error("packet image wrong");

  property p_range_bit;
    range_ev |=> pkt_ff[1];
  endproperty
  a_range_bit: assert property (p_range_bit) else $error("range hit not flagged");

  property p_rsvd_zero;
    pready_ff && !pwrite && (hit_base || hit_mask) |-> prdata_ff[31:28] == 4'h0;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits nonzero");

  property p_base_rsvd_low;
    pready_ff && !pwrite && hit_base |-> prdata_ff[1:0] == 2'h0;
  endproperty
  a_base_rsvd_low: assert property (p_base_rsvd_low) else $error("base low bits set");

endmodule : pmev_top

// ### verification/pmev_companion.sv
`timescale 1ns/1ps
module pmev_companion (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire pmev_pkg::pmev_pkt_t ser_pkt,
  output logic [7:0] pkt_data_ff,
  output int pkt_cnt_ff
);
  // Data is only trusted in the strobe cycle, so nothing else is latched.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pkt_data_ff <= 8'h00;
      pkt_cnt_ff <= 0;
    end else if (ser_pkt.strobe === 1'b1) begin
      pkt_data_ff <= ser_pkt.data;
      pkt_cnt_ff <= pkt_cnt_ff + 1;
    end
  end
endmodule : pmev_companion

// ### verification/pmev_top_test.sv
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("MISMATCH %0t got %0h exp %0h", $time, g, e); end end
module pmev_top_test;
  localparam int unsigned CA = 8;
  localparam int unsigned CB = 16;
  localparam int unsigned CC = 32;
  localparam logic [31:0] BA = 32'h01234560;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  pmev_pkg::pmev_cyc_t cpu_cyc = '0;
  pmev_pkg::pmev_pkt_t ser_pkt;
  logic irq;
  logic [7:0] pkt_data;
  int pkt_cnt;
  int n_fail = 0;
  int n_checks = 0;
  int cyc = 0;
  int n;
  logic [31:0] rd;
  logic err;
  logic [31:0] ca [7];
  logic cw [7];
  logic ce [7];
  int unsigned iv [3];

  pmev_top #(.CYC_A(CA), .CYC_B(CB), .CYC_C(CC)) u_pmev_top (
    .ref_clk(ref_clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cpu_cyc(cpu_cyc),
    .ser_pkt(ser_pkt), .irq(irq));
  pmev_companion u_pmev_companion (.ref_clk(ref_clk), .rst_n(rst_n),
    .ser_pkt(ser_pkt), .pkt_data_ff(pkt_data), .pkt_cnt_ff(pkt_cnt));

  initial begin
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic tally_and_finish();
    if (n_fail == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish

  // A hung handshake is cut off here rather than by a per-task limit.
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic cpu(input logic w, input logic v, input logic [31:0] a);
    @(posedge ref_clk);
    cpu_cyc <= '{1'b1, w, v, a};
    @(posedge ref_clk);
    cpu_cyc <= '0;
    repeat (3) @(posedge ref_clk);
  endtask : cpu

  task automatic wait_pkt(output int w);
    int k0;
    k0 = pkt_cnt;
    w = 0;
    while (pkt_cnt == k0) begin
      @(posedge ref_clk);
      w++;
    end
  endtask : wait_pkt

  initial begin
    ca = '{BA, BA, BA ^ 32'h100, BA ^ 32'h30, BA ^ 32'hf0000003, BA, BA};
    cw = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
    ce = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
    iv = '{CA, CB, CC};
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    apb(1'b0, pmev_pkg::RANGE_BASE_OFS, 32'h0);
    `CHK(rd, 32'h0)
    apb(1'b0, pmev_pkg::RANGE_MASK_OFS, 32'h0);
    `CHK(rd, 32'h0)
    apb(1'b0, 32'hffffff40, 32'h0);
    `CHK({err, rd}, 33'h100000000)
    apb(1'b1, pmev_pkg::RANGE_BASE_OFS, 32'hffffffff);
    apb(1'b0, pmev_pkg::RANGE_BASE_OFS, 32'h0);
    `CHK(rd, 32'h0ffffffc)
    apb(1'b1, pmev_pkg::RANGE_MASK_OFS, 32'hffffffff);
    apb(1'b0, pmev_pkg::RANGE_MASK_OFS, 32'h0);
    `CHK(rd, 32'h0fffffff)
    // A fully masked compare would flag every cycle, so turn it off again.
    apb(1'b1, pmev_pkg::RANGE_MASK_OFS, 32'h0);
    apb(1'b1, pmev_pkg::IRQ_EN_OFS, 32'h7);
    cpu(1'b0, 1'b1, 32'h0);
    apb(1'b0, pmev_pkg::PKT_OFS, 32'h0);
    `CHK(rd, 32'h0)
    apb(1'b1, pmev_pkg::CTRL_OFS, 32'h1);
    cpu(1'b0, 1'b1, 32'h0);
    cpu(1'b1, 1'b1, 32'h0);
    apb(1'b0, pmev_pkg::PKT_OFS, 32'h0);
    `CHK(rd, 32'h1)
    `CHK(irq, 1'b1)
    apb(1'b1, pmev_pkg::IRQ_EN_OFS, 32'h0);
    repeat (3) @(posedge ref_clk);
    `CHK(irq, 1'b0)
    apb(1'b1, pmev_pkg::IRQ_EN_OFS, 32'h7);
    apb(1'b1, pmev_pkg::IRQ_CLR_OFS, 32'h7);
    repeat (3) @(posedge ref_clk);
    `CHK(irq, 1'b0)
    apb(1'b1, pmev_pkg::RANGE_BASE_OFS, BA);
    apb(1'b1, pmev_pkg::RANGE_MASK_OFS, 32'hf1);
    for (int i = 0; i < 7; i++) begin
      if (i == 5) begin
        apb(1'b1, pmev_pkg::RANGE_MASK_OFS, 32'hf2);
      end
      cpu(cw[i], 1'b0, ca[i]);
      apb(1'b0, pmev_pkg::IRQ_STAT_OFS, 32'h0);
      `CHK(rd[1], ce[i])
      apb(1'b1, pmev_pkg::IRQ_CLR_OFS, 32'h2);
    end
    apb(1'b0, pmev_pkg::PKT_OFS, 32'h0);
    `CHK(rd, 32'h3)
    apb(1'b1, pmev_pkg::CTRL_OFS, 32'h9);
    wait_pkt(n);
    `CHK(pkt_data, 8'h03)
    apb(1'b0, pmev_pkg::PKT_OFS, 32'h0);
    `CHK(rd, 32'h0)
    apb(1'b0, pmev_pkg::IRQ_STAT_OFS, 32'h0);
    `CHK(rd[2], 1'b1)
    n = pkt_cnt;
    repeat (4 * CA) @(posedge ref_clk);
    `CHK(pkt_cnt, n)
    // Video reports are held on so the packet never empties while timing.
    cpu_cyc <= '{1'b1, 1'b0, 1'b1, 32'h0};
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, pmev_pkg::CTRL_OFS, 32'h1 | ((i + 1) << 3));
      wait_pkt(n);
      wait_pkt(n);
      wait_pkt(n);
      `CHK(n, iv[i])
    end
    `CHK(pkt_data, 8'h01)
    apb(1'b1, pmev_pkg::CTRL_OFS, 32'h1);
    cpu_cyc <= '0;
    n = pkt_cnt;
    repeat (100) @(posedge ref_clk);
    `CHK(pkt_cnt, n)
    tally_and_finish();
  end
endmodule : pmev_top_test
